// >>> core/tbpu_map.svh
// Register offsets, field positions, reset values for the three-bit port
`ifndef TBPU_MAP_SVH
`define TBPU_MAP_SVH
`define TBPU_OFF_PIN_LEVELS 12'h000
`define TBPU_OFF_OUT_LATCH 12'h004
`define TBPU_OFF_DIR_PULLUP 12'h008
`define TBPU_OFF_ANALOG_CFG 12'h00c
`define TBPU_OFF_PMP_CTRL 12'h010
`define TBPU_DIR_E_PU_BIT 6
`define TBPU_DIR_D_PU_BIT 7
`define TBPU_RST_LATCH 3'h0
`define TBPU_RST_DIR 3'h7
`define TBPU_RST_E_PU 1'h0
`define TBPU_RST_D_PU 1'h0
`define TBPU_RST_ANALOG 8'hff
`define TBPU_RST_PMP 1'h0
`endif

// >>> core/tbpu_pkg.sv
// Types shared by the three-bit port
package tbpu_pkg;
   typedef enum logic [1:0] {
      TBPU_IDLE,
      TBPU_DATA
   } tbpu_phase_t;
endpackage : tbpu_pkg

// >>> core/tbpu_pin_cell.sv
// One port pin: drive select, pull-up gating and digital input path
`timescale 1ns/100ps
module tbpu_pin_cell (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic latch_i,
   input wire logic dir_in_i,
   input wire logic analog_i,
   input wire logic pu_en_i,
   input wire logic pmp_own_i,
   input wire logic pmp_out_i,
   input wire logic pmp_oe_i,
   input wire logic pad_i,
   output logic pad_o,
   output logic pad_oe_n_o,
   output logic pullup_o,
   output logic level_o,
   output logic pmp_in_o
);
   typedef struct packed {
      logic pad;
      logic oe_n;
      logic pu;
      logic level;
      logic pmp_in;
   } tbpu_cell_t;
   tbpu_cell_t s_q;
   tbpu_cell_t s_d;
   logic drive;
   always_comb begin
      s_d = s_q;
      // Port owns the driver unless the parallel port took the pin
      drive = pmp_own_i ? pmp_oe_i : ~dir_in_i;
      s_d.oe_n = ~drive;
      s_d.pad = pmp_own_i ? pmp_out_i : latch_i;
      s_d.pu = pu_en_i & ~drive;
      // Analog selection blocks the digital path; both consumers see zero
      s_d.level = analog_i ? 1'b0 : pad_i;
      s_d.pmp_in = analog_i ? 1'b0 : pad_i;
   end
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         s_q <= '{pad: 1'b0, oe_n: 1'b1, pu: 1'b0, level: 1'b0, pmp_in: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end
   assign pad_o = s_q.pad;
   assign pad_oe_n_o = s_q.oe_n;
   assign pullup_o = s_q.pu;
   assign level_o = s_q.level;
   assign pmp_in_o = s_q.pmp_in;
endmodule : tbpu_pin_cell

// >>> core/tbpu_port.sv
// Three-bit GPIO port with pull-up control, AHB-Lite register slave
//
// Contract
// - The port has three pins, each independently input or output, sampled through a Schmitt input.
// - A pin selected as analog input reads as zero in the pin-level register.
// - Direction one makes the pin an input with driver off; zero drives the latch onto the pin.
// - Direction bits keep controlling the drivers even while pins are analog.
// - After reset all three pins are analog inputs.
// - The output latch is memory mapped and reads back the latch, not the pins.
// - Bit 6 of the direction register enables this port's pull-ups when one.
// - Bit 7 of the direction register enables the neighbour port's pull-ups when one.
// - A pin's pull-up is off whenever that pin is an output.
// - Reset leaves all pull-ups disabled.
// - The digital input path is disabled while a pin is analog.
// - The latch-driven output is unaffected by analog selection.
// - Under parallel port ownership pin 0 is read strobe, pin 1 write strobe, pin 2 byte enable.
// - Unimplemented bits of the port, latch and direction registers read as zero.
//
// Implementation choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
`include "tbpu_map.svh"
module tbpu_port
   import tbpu_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic hsel_i,
   input wire logic [11:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire logic [2:0] e_pin_i,
   output logic [2:0] e_pin_o,
   output logic [2:0] e_pin_oe_n_o,
   output logic [2:0] e_pullup_o,
   output logic d_port_pullup_enable_o,
   output logic [7:0] analog_select_o,
   input wire logic parallel_read_strobe_i,
   input wire logic parallel_write_strobe_i,
   input wire logic parallel_byte_enable_i,
   input wire logic parallel_read_oe_i,
   input wire logic parallel_write_oe_i,
   output logic parallel_read_strobe_o,
   output logic parallel_write_strobe_o
);
   // =====================================================================
   // State
   // =====================================================================
   typedef struct packed {
      tbpu_phase_t phase;
      logic [11:0] addr;
      logic wr;
      logic [31:0] rdata;
      logic [2:0] latch;
      logic [2:0] dir;
      logic e_pu;
      logic d_pu;
      logic [7:0] analog;
      logic pmp_own;
   } tbpu_state_t;
   tbpu_state_t s_q;
   tbpu_state_t s_d;
   logic [2:0] level;
   logic [2:0] pmp_in;
   logic [2:0] pmp_out;
   logic [2:0] pmp_oe;
   logic [2:0] pu_lane;

   function automatic logic [31:0] tbpu_read(input tbpu_state_t s, input logic [2:0] lv);
      logic [31:0] r;
      r = 32'h0;
      case (s.addr)
         `TBPU_OFF_PIN_LEVELS: r = {29'h0, lv};
         `TBPU_OFF_OUT_LATCH: r = {29'h0, s.latch};
         `TBPU_OFF_DIR_PULLUP: r = {24'h0, s.d_pu, s.e_pu, 3'h0, s.dir};
         `TBPU_OFF_ANALOG_CFG: r = {24'h0, s.analog};
         `TBPU_OFF_PMP_CTRL: r = {31'h0, s.pmp_own};
         default: r = 32'h0;
      endcase
      return r;
   endfunction : tbpu_read

   // =====================================================================
   // Register slave: zero wait state, always OKAY
   // =====================================================================
   always_comb begin
      s_d = s_q;
      if (s_q.phase == TBPU_DATA && s_q.wr) begin
         case (s_q.addr)
            `TBPU_OFF_PIN_LEVELS: s_d.latch = hwdata_i[2:0];
            `TBPU_OFF_OUT_LATCH: s_d.latch = hwdata_i[2:0];
            `TBPU_OFF_DIR_PULLUP: begin
               s_d.dir = hwdata_i[2:0];
               s_d.e_pu = hwdata_i[`TBPU_DIR_E_PU_BIT];
               s_d.d_pu = hwdata_i[`TBPU_DIR_D_PU_BIT];
            end
            `TBPU_OFF_ANALOG_CFG: s_d.analog = hwdata_i[7:0];
            `TBPU_OFF_PMP_CTRL: s_d.pmp_own = hwdata_i[0];
            default: s_d.pmp_own = s_q.pmp_own;
         endcase
      end
      if (hsel_i && hready_i && htrans_i[1]) begin
         s_d.phase = TBPU_DATA;
         s_d.addr = {haddr_i[11:2], 2'b00};
         s_d.wr = hwrite_i;
         s_d.rdata = 32'h0;
         if (!hwrite_i) begin
            s_d.addr = {haddr_i[11:2], 2'b00};
         end
      end else begin
         s_d.phase = TBPU_IDLE;
      end
      // Read data is captured one cycle early so hrdata comes from a flop
      if (hsel_i && hready_i && htrans_i[1] && !hwrite_i) begin
         s_d.rdata = tbpu_read('{phase: s_q.phase, addr: {haddr_i[11:2], 2'b00},
            wr: 1'b0, rdata: 32'h0, latch: s_d.latch, dir: s_d.dir, e_pu: s_d.e_pu,
            d_pu: s_d.d_pu, analog: s_d.analog, pmp_own: s_d.pmp_own}, level);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         s_q.phase <= TBPU_IDLE;
         s_q.addr <= 12'h0;
         s_q.wr <= 1'b0;
         s_q.rdata <= 32'h0;
         s_q.latch <= `TBPU_RST_LATCH;
         s_q.dir <= `TBPU_RST_DIR;
         s_q.e_pu <= `TBPU_RST_E_PU;
         s_q.d_pu <= `TBPU_RST_D_PU;
         s_q.analog <= `TBPU_RST_ANALOG;
         s_q.pmp_own <= `TBPU_RST_PMP;
      end else begin
         s_q <= s_d;
      end
   end

   assign hrdata_o = s_q.rdata;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign d_port_pullup_enable_o = s_q.d_pu;
   assign analog_select_o = s_q.analog;

   // =====================================================================
   // Pins: analog channels five to seven sit on bits 7:5 of the config
   // =====================================================================
   assign pmp_out = {parallel_byte_enable_i, parallel_write_strobe_i, parallel_read_strobe_i};
   assign pmp_oe = {1'b1, parallel_write_oe_i, parallel_read_oe_i};

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_pin
         tbpu_pin_cell u_cell (
            .core_clk_i(core_clk_i),
            .rst_i(rst_i),
            .latch_i(s_q.latch[g]),
            .dir_in_i(s_q.dir[g]),
            .analog_i(s_q.analog[5 + g]),
            .pu_en_i(s_q.e_pu),
            .pmp_own_i(s_q.pmp_own),
            .pmp_out_i(pmp_out[g]),
            .pmp_oe_i(pmp_oe[g]),
            .pad_i(e_pin_i[g]),
            .pad_o(e_pin_o[g]),
            .pad_oe_n_o(e_pin_oe_n_o[g]),
            .pullup_o(pu_lane[g]),
            .level_o(level[g]),
            .pmp_in_o(pmp_in[g])
         );
      end
   endgenerate
   assign e_pullup_o = pu_lane;
   assign parallel_read_strobe_o = pmp_in[0];
   assign parallel_write_strobe_o = pmp_in[1];
endmodule : tbpu_port

// >>> test/tbpu_assertions.sv
// Checker for the three-bit port
`timescale 1ns/100ps
module tbpu_assertions (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic hsel_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic [2:0] e_pin_oe_n_o,
   input wire logic [2:0] e_pullup_o,
   input wire logic d_port_pullup_enable_o,
   input wire logic [7:0] analog_select_o,
   input wire logic parallel_read_strobe_o,
   input wire logic parallel_write_strobe_o
);
   // ========
   // Properties
   logic rd_t;
   logic wr_t;
   assign rd_t = hsel_i & hready_i & htrans_i[1] & ~hwrite_i;
   assign wr_t = hsel_i & hready_i & htrans_i[1] & hwrite_i;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   okay_resp_a: assert property (hresp_o == 1'h0) else $error("bad hresp");
   ready_high_a: assert property (hreadyout_o) else $error("hreadyout low");
   pull_off_out_a: assert property ((e_pullup_o & ~e_pin_oe_n_o) == 3'h0)
      else $error("pull-up on driven pin");
   reset_state_a: assert property ($past(rst_i) |-> e_pin_oe_n_o == 3'h7
      && e_pullup_o == 3'h0 && analog_select_o == 8'hff && !d_port_pullup_enable_o)
      else $error("bad reset state");
   read_hold_a: assert property (!$past(rd_t | wr_t) |-> $stable(hrdata_o))
      else $error("hrdata moved");
   write_clear_a: assert property ($past(wr_t) |-> hrdata_o == 32'h0)
      else $error("hrdata not cleared by write");
   analog_rd_a: assert property (analog_select_o[5] && $past(analog_select_o[5])
      |-> !parallel_read_strobe_o) else $error("analog pin 0 seen");
   analog_wr_a: assert property (analog_select_o[6] && $past(analog_select_o[6])
      |-> !parallel_write_strobe_o) else $error("analog pin 1 seen");
   dpu_by_write_a: assert property ($changed(d_port_pullup_enable_o)
      |-> $past(wr_t, 2) || $past(wr_t, 3)) else $error("d pull-up moved");
   analog_by_write_a: assert property ($changed(analog_select_o)
      |-> $past(wr_t, 2) || $past(wr_t, 3)) else $error("analog moved");
endmodule : tbpu_assertions
bind tbpu_port tbpu_assertions i_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
   .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
   .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
   .e_pin_oe_n_o(e_pin_oe_n_o), .e_pullup_o(e_pullup_o),
   .d_port_pullup_enable_o(d_port_pullup_enable_o), .analog_select_o(analog_select_o),
   .parallel_read_strobe_o(parallel_read_strobe_o),
   .parallel_write_strobe_o(parallel_write_strobe_o));

// >>> test/tbpu_board.sv
// Board model of the three pads
`timescale 1ns/100ps
module tbpu_board (
   input wire logic core_clk_i,
   input wire logic [2:0] pin_i,
   input wire logic [2:0] oe_n_i,
   input wire logic [2:0] pu_i,
   input wire logic [2:0] ext_en_i,
   input wire logic [2:0] ext_v_i,
   output logic [2:0] pad_o
);
   // ========
   // Pad levels
   logic [2:0] last_q = 3'h0;
   // A floating pad flips each cycle so a stale level never passes
   assign pad_o = (~oe_n_i & pin_i) | (oe_n_i & ext_en_i & ext_v_i)
      | (oe_n_i & ~ext_en_i & (pu_i | ~last_q));
   always @(posedge core_clk_i) last_q <= pad_o;
endmodule : tbpu_board

// >>> test/testbench.sv
// Self-checking bench for the three-bit port
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
   // ========
   // Stimulus and model
   logic clk = 1'h0, rst = 1'h1, hsel = 1'h0, hwrite = 1'h0, hready, hresp, dpu, rso, wso;
   logic rs = 1'h0, ws = 1'h0, be = 1'h0, roe = 1'h0, woe = 1'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h0;
   logic [11:0] haddr = 12'h0;
   logic [31:0] hwdata = 32'h0, hrdata, rd, r, r2, r3;
   logic [2:0] pin, oe_n, pu, pad, ext_en = 3'h0, ext_v = 3'h0, lat, dir, an, eoe, epo, pl, m, ep;
   logic [7:0] ana;
   int failures = 0, check_count = 0;
   int unsigned s = 19;
   tbpu_port i_dut (.core_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .e_pin_i(pad), .e_pin_o(pin), .e_pin_oe_n_o(oe_n), .e_pullup_o(pu),
      .d_port_pullup_enable_o(dpu), .analog_select_o(ana), .parallel_read_strobe_i(rs),
      .parallel_write_strobe_i(ws), .parallel_byte_enable_i(be), .parallel_read_oe_i(roe),
      .parallel_write_oe_i(woe), .parallel_read_strobe_o(rso), .parallel_write_strobe_o(wso));
   tbpu_board i_brd (.core_clk_i(clk), .pin_i(pin), .oe_n_i(oe_n), .pu_i(pu),
      .ext_en_i(ext_en), .ext_v_i(ext_v), .pad_o(pad));
   initial begin
      forever #50 clk = ~clk;
   end
   function automatic logic [31:0] rnd();
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : rnd
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'h1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      hsize <= 3'h2;
      do @(posedge clk); while (hready !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'h1);
      rd = hrdata;
      `CHK(hresp, 1'h0);
   endtask : bus
   task automatic summarize();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : summarize
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      summarize();
   end
   initial begin
      int ev[6] = '{0, 0, 7, 'hff, 0, 0};
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      for (int i = 0; i < 6; i++) begin
         bus(1'h0, 12'(i * 4), 32'h0);
         `CHK(rd, 32'(ev[i]));
      end
      `CHK({oe_n, pu, dpu, ana}, 15'h70ff);
      $display("test reset done");
      repeat (24) begin
         r = rnd();
         r2 = rnd();
         r3 = rnd();
         lat = r[2:0];
         an = r3[7:5];
         dir = r2[2:0] | (an & {3{r3[20]}});
         bus(1'h1, r[3] ? 12'h004 : 12'h000, r);
         bus(1'h1, 12'h00c, r3);
         bus(1'h1, 12'h010, r3 >> 8);
         bus(1'h1, 12'h008, {r2[31:3], dir});
         {rs, ws, be, roe, woe} <= r3[13:9];
         ext_en <= r3[16:14];
         ext_v <= r3[19:17];
         repeat (4) @(posedge clk);
         // Parallel ownership overrides latch and direction
         eoe = r3[8] ? {1'h0, ~r3[9], ~r3[10]} : dir;
         epo = r3[8] ? {r3[11], r3[12], r3[13]} : lat;
         // Pull-up follows the enable on every pin that is not driven, whoever owns it
         pl = eoe & {3{r2[6]}};
         ep = (~eoe & epo) | (eoe & r3[16:14] & r3[19:17]) | (eoe & ~r3[16:14] & pl);
         m = ~eoe | r3[16:14] | pl | an;
         `CHK(oe_n, eoe);
         `CHK(pin & ~eoe, epo & ~eoe);
         `CHK(pu, pl);
         `CHK(dpu, r2[7]);
         `CHK(ana, r3[7:0]);
         if (m[0]) `CHK(rso, ep[0] & ~an[0]);
         if (m[1]) `CHK(wso, ep[1] & ~an[1]);
         bus(1'h0, 12'h000, 32'h0);
         `CHK(rd & {29'h1fffffff, m}, {29'h0, ep & ~an & m});
         bus(1'h0, 12'h004, 32'h0);
         `CHK(rd, {29'h0, lat});
         bus(1'h0, 12'h008, 32'h0);
         `CHK(rd, {24'h0, r2[7:6], 3'h0, dir});
      end
      $display("test random done");
      summarize();
   end
endmodule : testbench
